// >>> design/csdm_pkg.sv
// constants and types shared by the core stack and data memory block
package csdm_pkg;
	localparam int           DATA_W        = 8;
	localparam int           PC_W          = 15;
	localparam int           STACK_DEPTH   = 16;
	localparam logic [7:0]   ADDR_IND0     = 8'h00;
	localparam logic [7:0]   ADDR_PTR0     = 8'h01;
	localparam logic [7:0]   ADDR_IND1     = 8'h02;
	localparam logic [7:0]   ADDR_PTR1     = 8'h03;
	localparam logic [7:0]   ADDR_BANK     = 8'h04;
	localparam logic [7:0]   ADDR_ACC      = 8'h05;
	localparam logic [7:0]   ADDR_STATUS   = 8'h0A;
	localparam logic [7:0]   SFR_LAST      = 8'h2B;
	localparam logic [7:0]   GP_BASE       = 8'h40;
	localparam int           GP_SIZE       = 192;
	localparam int           GP_BANKS      = 4;
	localparam logic [7:0]   READ_ZERO     = 8'h00;
	localparam logic [7:0]   RESET_BYTE    = 8'h00;
	localparam int           FLAG_C        = 0;
	localparam int           FLAG_AC       = 1;
	localparam int           FLAG_Z        = 2;
	localparam int           FLAG_OV       = 3;

	typedef enum logic [4:0] {
		CSDM_OP_ADD   = 5'h00,
		CSDM_OP_ADC   = 5'h01,
		CSDM_OP_SUB   = 5'h02,
		CSDM_OP_SUBB  = 5'h03,
		CSDM_OP_DADJ  = 5'h04,
		CSDM_OP_AND   = 5'h05,
		CSDM_OP_OR    = 5'h06,
		CSDM_OP_XOR   = 5'h07,
		CSDM_OP_NOT   = 5'h08,
		CSDM_OP_RL    = 5'h09,
		CSDM_OP_RR    = 5'h0A,
		CSDM_OP_RLCY  = 5'h0B,
		CSDM_OP_RRCY  = 5'h0C,
		CSDM_OP_INC   = 5'h0D,
		CSDM_OP_DEC   = 5'h0E,
		CSDM_OP_PASS  = 5'h0F,
		CSDM_OP_SKZ   = 5'h10,
		CSDM_OP_SKNZ  = 5'h11,
		CSDM_OP_ISKZ  = 5'h12,
		CSDM_OP_DSKZ  = 5'h13,
		CSDM_OP_BSET  = 5'h14,
		CSDM_OP_BCLR  = 5'h15
	} csdm_alu_op_t;

	typedef enum logic [1:0] {
		CSDM_STK_IDLE = 2'b00,
		CSDM_STK_PUSH = 2'b01,
		CSDM_STK_POP  = 2'b10
	} csdm_stk_op_t;
endpackage

// >>> design/csdm_stack.sv
// sixteen-level return stack for the program counter
`timescale 1ns/10ps
module csdm_stack #(
	parameter int DEPTH = csdm_pkg::STACK_DEPTH,
	parameter int WIDTH = csdm_pkg::PC_W
) (
	input  wire logic                       clk,
	input  wire logic                       nrst,
	input  wire csdm_pkg::csdm_stk_op_t     op,
	input  wire logic [WIDTH-1:0]           push_pc,
	output logic      [WIDTH-1:0]           pop_pc,
	output logic                            full,
	output logic                            empty
);
	localparam int IW = $clog2(DEPTH);
	localparam int CW = IW + 1;

	if (DEPTH < 2 || (1 << IW) != DEPTH) begin : g_bad_depth
		$error("stack depth must be a power of two");
	end

	// not mapped anywhere: software has no path to the entries or the index
	logic [WIDTH-1:0] entry [DEPTH];
	logic [IW-1:0]    stack_level_index;
	logic [CW-1:0]    used;

	// index wraps, so a push when full overwrites the oldest slot
	always_ff @(posedge clk or negedge nrst) begin // see RQ19
		if (!nrst) begin
			stack_level_index <= '0; // see RQ4
		end else if (op == csdm_pkg::CSDM_STK_PUSH) begin
			stack_level_index <= stack_level_index + 1'b1; // see RQ2
		end else if (op == csdm_pkg::CSDM_STK_POP) begin
			stack_level_index <= stack_level_index - 1'b1; // see RQ3
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			used <= '0;
		end else if (op == csdm_pkg::CSDM_STK_PUSH && !full) begin
			used <= used + 1'b1;
		end else if (op == csdm_pkg::CSDM_STK_POP && !empty) begin
			used <= used - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (op == csdm_pkg::CSDM_STK_PUSH)
			entry[stack_level_index] <= push_pc; // see RQ6
	end

	assign pop_pc = entry[stack_level_index - 1'b1]; // see RQ3
	assign full   = (used == CW'(DEPTH)); // see RQ19
	assign empty  = (used == '0);
endmodule

// >>> design/csdm_alu.sv
// eight-bit alu with status flag generation
`timescale 1ns/10ps
module csdm_alu (
	input  wire csdm_pkg::csdm_alu_op_t op,
	input  wire logic [7:0]             a,
	input  wire logic [7:0]             b,
	input  wire logic [2:0]             bit_sel,
	input  wire logic [3:0]             flags_in,
	output logic      [7:0]             result,
	output logic      [3:0]             flags_out,
	output logic                        skip
);
	logic [8:0] sum;
	logic [4:0] low;
	logic [7:0] adj;
	logic       cin;
	logic       sub;
	logic [7:0] bop;

	always_comb begin // see RQ16
		result    = a;
		flags_out = flags_in;
		skip      = 1'b0;
		sum       = '0;
		low       = '0;
		adj       = '0;
		cin       = flags_in[csdm_pkg::FLAG_C];
		sub       = (op == csdm_pkg::CSDM_OP_SUB) || (op == csdm_pkg::CSDM_OP_SUBB);
		bop       = sub ? ~b : b;
		unique case (op)
			csdm_pkg::CSDM_OP_ADD, csdm_pkg::CSDM_OP_ADC,
			csdm_pkg::CSDM_OP_SUB, csdm_pkg::CSDM_OP_SUBB: begin
				// subtract is a + ~b + 1; carry set means no borrow
				if (op == csdm_pkg::CSDM_OP_ADD)
					cin = 1'b0;
				else if (op == csdm_pkg::CSDM_OP_SUB)
					cin = 1'b1;
				sum    = {1'b0, a} + {1'b0, bop} + 9'(cin);
				low    = {1'b0, a[3:0]} + {1'b0, bop[3:0]} + 5'(cin);
				result = sum[7:0];
				flags_out[csdm_pkg::FLAG_C]  = sum[8]; // see RQ18
				flags_out[csdm_pkg::FLAG_AC] = low[4];
				flags_out[csdm_pkg::FLAG_OV] = (a[7] == bop[7]) && (sum[7] != a[7]);
				flags_out[csdm_pkg::FLAG_Z]  = (sum[7:0] == 8'h00);
			end
			csdm_pkg::CSDM_OP_DADJ: begin
				// only carry is touched, as the adjust targets a stored copy
				adj = 8'h00;
				if (a[3:0] > 4'h9 || flags_in[csdm_pkg::FLAG_AC])
					adj[3:0] = 4'h6;
				if (a > 8'h99 || flags_in[csdm_pkg::FLAG_C])
					adj[7:4] = 4'h6;
				sum    = {1'b0, a} + {1'b0, adj};
				result = sum[7:0];
				flags_out[csdm_pkg::FLAG_C] = sum[8] | flags_in[csdm_pkg::FLAG_C];
			end
			csdm_pkg::CSDM_OP_AND, csdm_pkg::CSDM_OP_OR,
			csdm_pkg::CSDM_OP_XOR, csdm_pkg::CSDM_OP_NOT: begin
				if (op == csdm_pkg::CSDM_OP_AND)
					result = a & b;
				else if (op == csdm_pkg::CSDM_OP_OR)
					result = a | b;
				else if (op == csdm_pkg::CSDM_OP_XOR)
					result = a ^ b;
				else
					result = ~a;
				flags_out[csdm_pkg::FLAG_Z] = (result == 8'h00); // see RQ18
			end
			csdm_pkg::CSDM_OP_RL:
				result = {a[6:0], a[7]};
			csdm_pkg::CSDM_OP_RR:
				result = {a[0], a[7:1]};
			csdm_pkg::CSDM_OP_RLCY: begin
				result = {a[6:0], flags_in[csdm_pkg::FLAG_C]};
				flags_out[csdm_pkg::FLAG_C] = a[7];
			end
			csdm_pkg::CSDM_OP_RRCY: begin
				result = {flags_in[csdm_pkg::FLAG_C], a[7:1]};
				flags_out[csdm_pkg::FLAG_C] = a[0];
			end
			csdm_pkg::CSDM_OP_INC, csdm_pkg::CSDM_OP_DEC: begin
				result = (op == csdm_pkg::CSDM_OP_INC) ? a + 8'h01 : a - 8'h01;
				flags_out[csdm_pkg::FLAG_Z] = (result == 8'h00);
			end
			csdm_pkg::CSDM_OP_SKZ, csdm_pkg::CSDM_OP_SKNZ: begin
				result = a;
				skip   = (op == csdm_pkg::CSDM_OP_SKZ) ? (a == 8'h00) : (a != 8'h00);
			end
			csdm_pkg::CSDM_OP_ISKZ, csdm_pkg::CSDM_OP_DSKZ: begin
				result = (op == csdm_pkg::CSDM_OP_ISKZ) ? a + 8'h01 : a - 8'h01;
				skip   = (result == 8'h00);
			end
			csdm_pkg::CSDM_OP_BSET:
				result = a | (8'h01 << bit_sel);
			csdm_pkg::CSDM_OP_BCLR:
				result = a & ~(8'h01 << bit_sel);
			csdm_pkg::CSDM_OP_PASS:
				result = b;
			default: begin
				result = a;
			end
		endcase
	end
endmodule

// >>> design/csdm_core.sv
// core data path: return stack, banked data memory, indirect ports, accumulator and alu
// Operation
// RQ1: sixteen-entry pc return stack, invisible to instructions along with its index.
// RQ2: call or interrupt acknowledge pushes pc and advances the index.
// RQ3: either return reloads pc from last entry and steps index back.
// RQ4: after reset the index designates the empty top of stack.
// RQ5: full stack withholds interrupt acknowledge until a return frees a level.
// RQ6: call on a full stack still pushes, losing the oldest entry.
// RQ7: special function registers appear identically in every bank.
// RQ8: unimplemented locations below 40H read 00H in every bank.
// RQ9: general memory 40H to FFH, 192 bytes, banks 0, 2, 3, 4.
// RQ10: every location takes alu operations and single-bit set or clear.
// RQ11: locations 00H and 02H access memory addressed by pointer zero or one.
// RQ12: an indirect access that points at an indirect port reads 00H, writes nothing.
// RQ13: software must not move data from one indirect port to the other.
// RQ14: pointers are 8 bits; pointer zero reaches bank 0, pointer one selected bank.
// RQ15: accumulator sits at 05H, takes immediates, carries memory-to-memory moves.
// RQ16: alu does add, subtract, decimal adjust, logic, rotate, inc, dec, skip tests.
// RQ17: every alu operation writes its result and updates affected status flags.
// RQ18: zero, carry, half carry and overflow follow each operation's result.
// RQ19: index is a wrapping 4-bit counter; full at sixteen; overwrite is circular.
`timescale 1ns/10ps
module csdm_core #(
	parameter int PC_WIDTH = csdm_pkg::PC_W
) (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	// program flow
	input  wire logic                          call_op,
	input  wire logic                          subroutine_return_op,
	input  wire logic                          interrupt_return_op,
	input  wire logic                          irq_pending,
	input  wire logic [PC_WIDTH-1:0]           pc_now,
	output logic                               irq_ack,
	output logic      [PC_WIDTH-1:0]           pc_return,
	output logic                               pc_load,
	output logic                               stack_full,
	// instruction execution
	input  wire logic                          exec,
	input  wire csdm_pkg::csdm_alu_op_t        alu_op,
	input  wire logic                          use_imm,
	input  wire logic [7:0]                    imm,
	input  wire logic [7:0]                    mem_addr,
	input  wire logic [2:0]                    bit_sel,
	input  wire logic                          to_mem,
	input  wire logic                          to_acc,
	output logic      [7:0]                    rd_data,
	output logic                               skip,
	// peripheral special registers outside this block, then the core's own registers
	output logic                               sfr_wr,
	output logic      [7:0]                    sfr_addr,
	output logic      [7:0]                    sfr_wdata,
	input  wire logic [7:0]                    sfr_rdata,
	output logic      [7:0]                    accumulator,
	output logic      [7:0]                    bank_select,
	output logic      [3:0]                    status_flags
);
	if (PC_WIDTH < 1 || PC_WIDTH > 16) begin : g_bad_width
		$error("pc width out of range");
	end

	localparam int GPA_W = $clog2(csdm_pkg::GP_SIZE * csdm_pkg::GP_BANKS);

	logic [7:0] memory_pointer_zero;
	logic [7:0] memory_pointer_one;
	logic [7:0] gp_mem [csdm_pkg::GP_SIZE * csdm_pkg::GP_BANKS];

	logic [7:0]       eff_addr;
	logic [7:0]       eff_bank;
	logic             ind_null;
	logic [7:0]       operand;
	logic [7:0]       alu_b;
	logic [7:0]       alu_res;
	logic [3:0]       alu_flags;
	logic             alu_skip;
	logic             gp_hit;
	logic [GPA_W-1:0] gp_index;
	logic             wr_en;
	logic             ret_any;
	csdm_pkg::csdm_stk_op_t stk_op;
	logic             stk_empty;

	// maps a bank selection value to a slot of the storage array
	function automatic logic [1:0] bank_slot(input logic [7:0] bank);
		unique case (bank)
			8'h02:   bank_slot = 2'h1;
			8'h03:   bank_slot = 2'h2;
			8'h04:   bank_slot = 2'h3;
			default: bank_slot = 2'h0;
		endcase
	endfunction

	// true when an address names one of the two indirect ports
	function automatic logic is_ind_port(input logic [7:0] addr);
		is_ind_port = (addr == csdm_pkg::ADDR_IND0) || (addr == csdm_pkg::ADDR_IND1);
	endfunction

	// indirect resolution: port zero always lands in bank 0
	always_comb begin // see RQ11
		eff_addr = mem_addr;
		eff_bank = bank_select;
		ind_null = 1'b0;
		if (mem_addr == csdm_pkg::ADDR_IND0) begin
			eff_addr = memory_pointer_zero;
			eff_bank = csdm_pkg::RESET_BYTE; // see RQ14
			ind_null = is_ind_port(memory_pointer_zero); // see RQ12
		end else if (mem_addr == csdm_pkg::ADDR_IND1) begin
			eff_addr = memory_pointer_one;
			eff_bank = bank_select; // see RQ14
			ind_null = is_ind_port(memory_pointer_one); // see RQ12
		end
	end

	// undefined bank codes fall onto bank 0 storage rather than a fifth bank
	assign gp_hit   = (eff_addr >= csdm_pkg::GP_BASE) && !ind_null; // see RQ9
	assign gp_index = GPA_W'(bank_slot(eff_bank)) * GPA_W'(csdm_pkg::GP_SIZE)
		+ GPA_W'(eff_addr - csdm_pkg::GP_BASE);

	// the sfr window ignores the bank value entirely
	always_comb begin // see RQ7
		operand = csdm_pkg::READ_ZERO;
		if (ind_null) begin
			operand = csdm_pkg::READ_ZERO; // see RQ12
		end else if (gp_hit) begin
			operand = gp_mem[gp_index];
		end else begin
			unique case (eff_addr)
				csdm_pkg::ADDR_PTR0:   operand = memory_pointer_zero;
				csdm_pkg::ADDR_PTR1:   operand = memory_pointer_one;
				csdm_pkg::ADDR_BANK:   operand = bank_select;
				csdm_pkg::ADDR_ACC:    operand = accumulator; // see RQ15
				csdm_pkg::ADDR_STATUS: operand = {4'h0, status_flags};
				default: begin
					// holes above the sfr block read zero
					if (eff_addr > csdm_pkg::SFR_LAST)
						operand = csdm_pkg::READ_ZERO; // see RQ8
					else
						operand = sfr_rdata;
				end
			endcase
		end
	end

	assign alu_b = use_imm ? imm : accumulator; // see RQ15

	csdm_alu u_alu (
		.op        (alu_op),
		.a         (operand),
		.b         (alu_b),
		.bit_sel   (bit_sel),
		.flags_in  (status_flags),
		.flags_out (alu_flags),
		.result    (alu_res),
		.skip      (alu_skip)
	);

	assign wr_en     = exec && to_mem && !ind_null; // see RQ10
	assign rd_data   = operand;
	assign skip      = exec && alu_skip;
	assign sfr_addr  = eff_addr;
	assign sfr_wdata = alu_res;
	assign sfr_wr    = wr_en && !gp_hit && (eff_addr <= csdm_pkg::SFR_LAST)
		&& (eff_addr != csdm_pkg::ADDR_PTR0) && (eff_addr != csdm_pkg::ADDR_PTR1)
		&& (eff_addr != csdm_pkg::ADDR_BANK) && (eff_addr != csdm_pkg::ADDR_ACC)
		&& (eff_addr != csdm_pkg::ADDR_STATUS);

	// general purpose storage has no reset: contents are undefined at power up
	always_ff @(posedge clk) begin
		if (wr_en && gp_hit)
			gp_mem[gp_index] <= alu_res; // see RQ10
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			memory_pointer_zero <= csdm_pkg::RESET_BYTE;
			memory_pointer_one  <= csdm_pkg::RESET_BYTE;
			bank_select         <= csdm_pkg::RESET_BYTE;
		end else if (wr_en && !gp_hit) begin
			if (eff_addr == csdm_pkg::ADDR_PTR0)
				memory_pointer_zero <= alu_res; // see RQ14
			if (eff_addr == csdm_pkg::ADDR_PTR1)
				memory_pointer_one <= alu_res;
			if (eff_addr == csdm_pkg::ADDR_BANK)
				bank_select <= alu_res;
		end
	end

	// a destination write to the accumulator and to_acc agree on the value
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			accumulator <= csdm_pkg::RESET_BYTE;
		end else if (exec && (to_acc || (wr_en && !gp_hit && eff_addr == csdm_pkg::ADDR_ACC))) begin
			accumulator <= alu_res; // see RQ15
		end
	end

	// alu flags that differ from the current flags win over a plain store to the status location
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_flags <= 4'h0;
		end else if (exec) begin
			if (wr_en && !gp_hit && eff_addr == csdm_pkg::ADDR_STATUS)
				status_flags <= alu_res[3:0];
			if (alu_flags != status_flags)
				status_flags <= alu_flags; // see RQ17
		end
	end

	// return stack control
	assign ret_any  = subroutine_return_op || interrupt_return_op;
	// interrupt waits while full, and also in any cycle that carries a call or a return
	assign irq_ack  = irq_pending && !stack_full && !call_op && !ret_any; // see RQ5
	assign pc_load  = ret_any && !stk_empty;

	always_comb begin
		stk_op = csdm_pkg::CSDM_STK_IDLE;
		if (ret_any && !stk_empty)
			stk_op = csdm_pkg::CSDM_STK_POP; // see RQ3
		else if (call_op || irq_ack)
			stk_op = csdm_pkg::CSDM_STK_PUSH; // see RQ2
	end

	csdm_stack #(
		.DEPTH (csdm_pkg::STACK_DEPTH),
		.WIDTH (PC_WIDTH)
	) u_stack (
		.clk     (clk),
		.nrst    (nrst),
		.op      (stk_op),
		.push_pc (pc_now),
		.pop_pc  (pc_return),
		.full    (stack_full),
		.empty   (stk_empty)
	); // see RQ1
endmodule

// >>> bench/csdm_core_checker.sv
// concurrent checks on the core data path ports
`timescale 1ns/10ps
module csdm_core_checker #(
	parameter int PC_WIDTH = csdm_pkg::PC_W
) (
	input wire logic                   clk,
	input wire logic                   nrst,
	input wire logic                   call_op,
	input wire logic                   subroutine_return_op,
	input wire logic                   interrupt_return_op,
	input wire logic                   irq_pending,
	input wire logic [PC_WIDTH-1:0]    pc_now,
	input wire logic                   irq_ack,
	input wire logic [PC_WIDTH-1:0]    pc_return,
	input wire logic                   pc_load,
	input wire logic                   stack_full,
	input wire logic                   exec,
	input wire csdm_pkg::csdm_alu_op_t alu_op,
	input wire logic                   use_imm,
	input wire logic [7:0]             imm,
	input wire logic [7:0]             mem_addr,
	input wire logic                   to_mem,
	input wire logic                   to_acc,
	input wire logic [7:0]             rd_data,
	input wire logic [7:0]             accumulator,
	input wire logic [3:0]             status_flags
);
	logic       ret;
	logic [7:0] and_res;
	assign ret = subroutine_return_op | interrupt_return_op;
	assign and_res = rd_data & imm;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	sequence s_call;
		call_op && !ret;
	endsequence
	sequence s_ret;
		ret && !call_op;
	endsequence
	property p_load_cause;
		pc_load |-> ret;
	endproperty
	a_load_cause: assert property (p_load_cause) else $error("pc load without a return");
	property p_call_ret;
		s_call ##1 s_ret |-> pc_load && pc_return == $past(pc_now);
	endproperty
	a_call_ret: assert property (p_call_ret) else $error("return did not give the pushed pc");
	property p_full_block;
		stack_full |-> !irq_ack;
	endproperty
	a_full_block: assert property (p_full_block) else $error("interrupt taken on a full stack");
	property p_ack_cause;
		irq_ack |-> irq_pending && !call_op && !ret;
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without a free request");
	property p_ack_free;
		irq_pending && !stack_full && !call_op && !ret |-> irq_ack;
	endproperty
	a_ack_free: assert property (p_ack_free) else $error("request not acknowledged");
	property p_full_keep;
		stack_full ##0 s_call |=> stack_full;
	endproperty
	a_full_keep: assert property (p_full_keep) else $error("call on full stack lost fullness");
	property p_full_free;
		stack_full && ret |=> !stack_full;
	endproperty
	a_full_free: assert property (p_full_free) else $error("return left stack full");
	property p_reset_top;
		$rose(nrst) |-> !stack_full && !pc_load;
	endproperty
	a_reset_top: assert property (p_reset_top) else $error("stack not empty after reset");
	property p_unmapped;
		mem_addr inside {[8'h2C:8'h3F]} |-> rd_data == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("reserved location not zero");
	property p_and_acc;
		exec && alu_op == csdm_pkg::CSDM_OP_AND && use_imm && to_acc && !to_mem
			|=> accumulator == $past(and_res) && status_flags[2] == ($past(and_res) == 8'h00);
	endproperty
	a_and_acc: assert property (p_and_acc) else $error("and result or zero flag wrong");
endmodule

bind csdm_core csdm_core_checker #(.PC_WIDTH(PC_WIDTH)) i_chk (
	.clk(clk), .nrst(nrst), .call_op(call_op), .subroutine_return_op(subroutine_return_op),
	.interrupt_return_op(interrupt_return_op), .irq_pending(irq_pending), .pc_now(pc_now),
	.irq_ack(irq_ack), .pc_return(pc_return), .pc_load(pc_load), .stack_full(stack_full),
	.exec(exec), .alu_op(alu_op), .use_imm(use_imm), .imm(imm), .mem_addr(mem_addr),
	.to_mem(to_mem), .to_acc(to_acc), .rd_data(rd_data), .accumulator(accumulator),
	.status_flags(status_flags)
);

// >>> bench/tb_csdm_core.sv
// self-checking bench for the core data path
`timescale 1ns/10ps
module tb_csdm_core;
	logic                   clk = 1'h0, nrst = 1'h0, call_op = 1'h0, ret_op = 1'h0, iret_op = 1'h0;
	logic                   irq = 1'h0, exec = 1'h0, use_imm = 1'h1, to_mem = 1'h0, to_acc = 1'h0;
	logic                   irq_ack, pc_load, stack_full, skip, sfr_wr;
	logic [14:0]            pc_now = 15'h0000, pc_return;
	logic [7:0]             imm = 8'h00, mem_addr = 8'h2C, sfr_rdata = 8'h3C;
	logic [7:0]             rd_data, sfr_addr, sfr_wdata, accumulator, bank_select;
	logic [3:0]             status_flags;
	logic [2:0]             bit_sel = 3'h3;
	csdm_pkg::csdm_alu_op_t alu_op = csdm_pkg::CSDM_OP_OR;
	int                     n_errors = 0, n_compared = 0, cycles = 0;

	csdm_core i_dut (
		.clk(clk), .nrst(nrst), .call_op(call_op), .subroutine_return_op(ret_op),
		.interrupt_return_op(iret_op), .irq_pending(irq), .pc_now(pc_now), .irq_ack(irq_ack),
		.pc_return(pc_return), .pc_load(pc_load), .stack_full(stack_full), .exec(exec),
		.alu_op(alu_op), .use_imm(use_imm), .imm(imm), .mem_addr(mem_addr), .bit_sel(bit_sel),
		.to_mem(to_mem), .to_acc(to_acc), .rd_data(rd_data), .skip(skip), .sfr_wr(sfr_wr),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.accumulator(accumulator), .bank_select(bank_select), .status_flags(status_flags)
	);

	always #10 clk = ~clk;

	// a hang anywhere ends the run as a failure
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// k is {call, return, interrupt return, request}
	task automatic stk(input logic [3:0] k, input logic [14:0] pc);
		@(posedge clk);
		{call_op, ret_op, iret_op, irq} <= k;
		pc_now <= pc;
		#2;
	endtask

	// dst is {to_mem, to_acc}; operand a comes from location a
	task automatic ex(input logic [4:0] op, input logic [7:0] b, input logic [7:0] a, input logic [1:0] dst);
		@(posedge clk);
		exec <= 1'h1;
		alu_op <= csdm_pkg::csdm_alu_op_t'(op);
		imm <= b;
		mem_addr <= a;
		{to_mem, to_acc} <= dst;
		#2;
	endtask

	// and with zero first: general memory powers up unknown
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		ex(5'h05, 8'h00, a, 2'h2);
		ex(5'h06, v, a, 2'h2);
	endtask

	task automatic ld(input logic [7:0] v);
		ex(5'h06, v, 8'h2C, 2'h1);
	endtask

	task automatic alu(input logic [4:0] op, input logic [7:0] b, input logic [7:0] r,
			input logic [3:0] fm, input logic [3:0] fe, input logic sk);
		ex(op, b, 8'h05, 2'h1);
		check(skip, sk);
		@(posedge clk);
		exec <= 1'h0;
		#2;
		check(accumulator, r);
		check(status_flags & fm, fe);
	endtask

	task automatic t_stack();
		stk(4'h8, 15'h1234);
		stk(4'h4, 15'h0000);
		check(pc_return, 15'h1234);
		stk(4'h4, 15'h0000);
		check(pc_load, 1'h0);
		for (int i = 0; i < 16; i++)
			stk(4'h8, 15'(i));
		stk(4'h1, 15'h7000);
		check(stack_full, 1'h1);
		check(irq_ack, 1'h0);
		stk(4'h8, 15'h0100);
		stk(4'h4, 15'h0000);
		check(pc_return, 15'h0100);
		stk(4'h1, 15'h0200);
		check(irq_ack, 1'h1);
		for (int i = 16; i > 0; i--) begin
			stk(i[0] ? 4'h4 : 4'h2, 15'h0000);
			check(pc_return, i == 16 ? 15'h0200 : 15'(i));
		end
		stk(4'h2, 15'h0000);
		check(pc_load, 1'h0);
		stk(4'h0, 15'h0000);
	endtask

	task automatic t_mem();
		wr(8'h04, 8'h02);
		wr(8'h03, 8'h40);
		wr(8'h02, 8'hB2);
		wr(8'h04, 8'h00);
		wr(8'h40, 8'h11);
		wr(8'h01, 8'h40);
		ex(5'h06, 8'h00, 8'h40, 2'h0);
		check(rd_data, 8'h11);
		wr(8'h04, 8'h02);
		ex(5'h06, 8'h00, 8'h40, 2'h0);
		check(bank_select, 8'h02);
		check(rd_data, 8'hB2);
		ex(5'h06, 8'h00, 8'h02, 2'h0);
		check(rd_data, 8'hB2);
		ex(5'h06, 8'h00, 8'h00, 2'h0);
		check(rd_data, 8'h11);
		ex(5'h06, 8'h00, 8'h0C, 2'h2);
		check({sfr_wr, sfr_addr, sfr_wdata}, 17'h10C3C);
		wr(8'h2C, 8'h55);
		ex(5'h06, 8'h00, 8'h2C, 2'h0);
		check(rd_data, 8'h00);
		wr(8'h01, 8'h02);
		ex(5'h06, 8'h00, 8'h00, 2'h0);
		check(rd_data, 8'h00);
		wr(8'h00, 8'h77);
		ex(5'h06, 8'h00, 8'h02, 2'h0);
		check(rd_data, 8'hB2);
	endtask

	task automatic t_alu();
		ld(8'h7F);
		alu(5'h00, 8'h01, 8'h80, 4'hF, 4'hA, 1'h0);
		ld(8'hFF);
		alu(5'h00, 8'h01, 8'h00, 4'hF, 4'h7, 1'h0);
		alu(5'h01, 8'h01, 8'h02, 4'hF, 4'h0, 1'h0);
		ld(8'h33);
		alu(5'h02, 8'h33, 8'h00, 4'hF, 4'h7, 1'h0);
		alu(5'h03, 8'h00, 8'h00, 4'hF, 4'h7, 1'h0);
		ld(8'h0F);
		alu(5'h05, 8'hF0, 8'h00, 4'h4, 4'h4, 1'h0);
		ld(8'h0F);
		alu(5'h06, 8'hF0, 8'hFF, 4'h4, 4'h0, 1'h0);
		alu(5'h07, 8'h0F, 8'hF0, 4'h4, 4'h0, 1'h0);
		ld(8'h81);
		alu(5'h09, 8'h00, 8'h03, 4'h1, 4'h1, 1'h0);
		alu(5'h0A, 8'h00, 8'h81, 4'h1, 4'h1, 1'h0);
		alu(5'h0B, 8'h00, 8'h03, 4'h1, 4'h1, 1'h0);
		alu(5'h0C, 8'h00, 8'h81, 4'h1, 4'h1, 1'h0);
		alu(5'h08, 8'h00, 8'h7E, 4'h4, 4'h0, 1'h0);
		alu(5'h0D, 8'h00, 8'h7F, 4'h4, 4'h0, 1'h0);
		alu(5'h0E, 8'h00, 8'h7E, 4'h4, 4'h0, 1'h0);
		ld(8'h01);
		alu(5'h00, 8'h01, 8'h02, 4'hF, 4'h0, 1'h0);
		ld(8'h0A);
		alu(5'h04, 8'h00, 8'h10, 4'h1, 4'h0, 1'h0);
		ld(8'h00);
		alu(5'h14, 8'h00, 8'h08, 4'h0, 4'h0, 1'h0);
		alu(5'h15, 8'h00, 8'h00, 4'h0, 4'h0, 1'h0);
		alu(5'h10, 8'h00, 8'h00, 4'h0, 4'h0, 1'h1);
		alu(5'h11, 8'h00, 8'h00, 4'h0, 4'h0, 1'h0);
		ld(8'hFF);
		alu(5'h12, 8'h00, 8'h00, 4'h0, 4'h0, 1'h1);
		ld(8'h01);
		alu(5'h13, 8'h00, 8'h00, 4'h0, 4'h0, 1'h1);
		alu(5'h0F, 8'h5A, 8'h5A, 4'hF, 4'h0, 1'h0);
	endtask

	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'h1;
		t_stack();
		t_mem();
		t_alu();
		conclude();
	end
endmodule
